// ---- drive_ref.sv ----
`timescale 1ns/1ps
`default_nettype none
module drive_ref
    import drive_ref_pkg::*;
#(
    parameter logic [47:0] DAY_CYCLES_P = DAY_CYCLES
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // terminal strip pins
    input  wire logic [2:0]  preset_sw_i,
    input  wire logic        term_rev_i,
    // regulator side
    input  wire logic        running_i,
    input  wire logic        ref_neg_i,
    input  wire logic [15:0] analog_ref_i,
    input  wire logic [15:0] speed_rpm_i,
    input  wire logic [15:0] out_freq_i,
    output logic             dir_rev_o,
    output logic [15:0]      speed_ref_o
);
    import drive_ref_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT} seq_type;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] clamp16(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  sel);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta_r <= 4'h0;
            pin_sync_r <= 4'h0;
        end else begin
            pin_meta_r <= {term_rev_i, preset_sw_i};
            pin_sync_r <= pin_meta_r;
        end
    end
    wire [2:0] preset_code = pin_sync_r[2:0];
    wire       term_rev    = pin_sync_r[3];

    // ****************************************
    // registers
    // ****************************************
    logic [7:0]  ctrl_r;
    logic [15:0] scale_r, top_r, base_r, min_r, max_r, manual_r;
    logic [15:0] preset_r [8];
    logic        mreset_r;
    logic [15:0] days_r;
    logic [47:0] subday_r;
    logic        run_prev_r;
    logic        dir_latch_r;
    logic [15:0] dspeed_r, dref_r, minlim_r, maxlim_r;

    wire [1:0] policy   = ctrl_r[CTRL_POL_LSB +: 2];
    wire       vec_mode = ctrl_r[CTRL_VEC_BIT];
    wire [2:0] ref_src  = ctrl_r[CTRL_SRC_LSB +: 3];
    wire       sw_rev   = ctrl_r[CTRL_REV_BIT];
    wire       use_term = ctrl_r[CTRL_TRM_BIT];

    // ****************************************
    // bus decode
    // ****************************************
    wire         bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire         bus_wr   = bus_req && wb_we_i;
    wire [7:0]   adr      = {wb_adr_i[7:2], 2'b00};
    wire         is_pre   = (adr >= OFS_PRESET0) && (adr <= OFS_PRESET7);
    wire [2:0]   pre_idx  = 3'(adr[4:2]);
    wire [15:0]  wr_scale = clamp16(merge16(scale_r, wb_dat_i, wb_sel_i),
                                    SCALE_MIN, SCALE_MAX);
    wire [15:0]  wr_pre   = clamp16(merge16(preset_r[pre_idx], wb_dat_i,
                                    wb_sel_i), min_r, max_r);
    wire [15:0]  manlim   = clamp16(manual_r, minlim_r, maxlim_r);
    wire [15:0]  status   = {8'h00, preset_code, dir_latch_r, dir_rev_o,
                             running_i, policy};

    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (is_pre) begin
            rd_mux = preset_r[pre_idx];
        end else begin
            case (adr)
                OFS_CTRL:   rd_mux = {8'h00, ctrl_r};
                OFS_SCALE:  rd_mux = scale_r;
                OFS_TOP:    rd_mux = top_r;
                OFS_BASE:   rd_mux = base_r;
                OFS_MIN:    rd_mux = min_r;
                OFS_MAX:    rd_mux = max_r;
                OFS_MANUAL: rd_mux = manual_r;
                OFS_MRESET: rd_mux = {15'h0000, mreset_r};
                OFS_DAYS:   rd_mux = days_r;
                OFS_LOGCLK: rd_mux = subday_r[47:32];
                OFS_STATUS: rd_mux = status;
                OFS_DSPEED: rd_mux = dspeed_r;
                OFS_DREF:   rd_mux = dref_r;
                OFS_MINLIM: rd_mux = minlim_r;
                OFS_MAXLIM: rd_mux = maxlim_r;
                OFS_MANLIM: rd_mux = manlim;
                default:    rd_mux = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? {16'h0000, rd_mux} : 32'h0;
        end
    end

    // ****************************************
    // control register; policy 1 pins the
    // panel/serial direction to forward
    // ****************************************
    wire [7:0] ctrl_wr  = (bus_wr && adr == OFS_CTRL && wb_sel_i[0])
                          ? wb_dat_i[7:0] : ctrl_r;
    wire       force_fw = ctrl_wr[CTRL_POL_LSB +: 2] == POL_NOREV;
    wire [7:0] ctrl_nxt = force_fw ? (ctrl_wr & ~(8'h01 << CTRL_REV_BIT))
                                   : ctrl_wr;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r   <= CTRL_RST;
            scale_r  <= SCALE_RST;
            top_r    <= TOP_RST;
            base_r   <= BASE_RST;
            min_r    <= MIN_RST;
            max_r    <= MAX_RST;
            manual_r <= MIN_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (bus_wr) begin
                case (adr)
                    OFS_SCALE:  scale_r  <= wr_scale;
                    OFS_TOP:    top_r    <= merge16(top_r, wb_dat_i, wb_sel_i);
                    OFS_BASE:   base_r   <= merge16(base_r, wb_dat_i,
                                                    wb_sel_i);
                    OFS_MIN:    min_r    <= merge16(min_r, wb_dat_i, wb_sel_i);
                    OFS_MAX:    max_r    <= merge16(max_r, wb_dat_i, wb_sel_i);
                    OFS_MANUAL: manual_r <= merge16(manual_r, wb_dat_i,
                                                    wb_sel_i);
                    default:    ;
                endcase
            end
        end
    end

    // presets are clamped to min..max on write; a later min or max write does not reclamp them
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 8; i++) begin
                preset_r[i] <= PRESET_RST;
            end
        end else if (bus_wr && is_pre) begin
            preset_r[pre_idx] <= wr_pre;
        end
    end

    // ****************************************
    // elapsed days meter
    // ****************************************
    wire mreset_wr  = bus_wr && adr == OFS_MRESET && wb_sel_i[0]
                      && wb_dat_i[0];
    wire day_done   = subday_r == DAY_CYCLES_P - 48'h1;
    wire [15:0] days_inc = (days_r == DAYS_MAX) ? days_r : days_r + 16'h1;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mreset_r <= 1'b0;
            days_r   <= 16'h0000;
            subday_r <= 48'h0;
        end else begin
            mreset_r <= mreset_wr;
            if (mreset_r) begin
                days_r   <= 16'h0000;
                subday_r <= 48'h0;
            end else if (day_done) begin
                subday_r <= 48'h0;
                days_r   <= days_inc;
            end else begin
                subday_r <= subday_r + 48'h1;
            end
        end
    end

    // ****************************************
    // direction policy
    // ****************************************
    wire req_rev   = use_term ? term_rev : sw_rev;
    wire run_start = running_i && !run_prev_r;
    wire rev_base  = (policy == POL_LATCH) ? dir_latch_r : req_rev;
    // polarity of the reference still flips direction except under policy 1
    wire rev_nxt   = (policy == POL_NOREV) ? 1'b0
                   : (rev_base ^ ref_neg_i);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_prev_r  <= 1'b0;
            dir_latch_r <= 1'b0;
            dir_rev_o   <= 1'b0;
        end else begin
            run_prev_r <= running_i;
            dir_rev_o  <= rev_nxt;
            if (!running_i || run_start) begin
                dir_latch_r <= req_rev;
            end
        end
    end

    // ****************************************
    // reference select, never scaled
    // ****************************************
    wire in_pre   = (ref_src >= SRC_PRE_LO) && (ref_src <= SRC_PRE_HI);
    wire zero_ana = ref_src >= SRC_ANA_LO;
    wire [15:0] pre_ref = (preset_code == 3'h0 && zero_ana)
                          ? analog_ref_i : preset_r[preset_code];
    wire [15:0] sel_ref = in_pre ? pre_ref : analog_ref_i;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            speed_ref_o <= 16'h0000;
        end else begin
            speed_ref_o <= sel_ref;
        end
    end

    // ****************************************
    // display scaling sequencer
    // ****************************************
    seq_type     st_r;
    logic [1:0]  job_r;
    logic        div_start;
    logic        div_done;
    logic [15:0] div_quo;
    wire  [15:0] den     = vec_mode ? top_r : base_r;
    wire  [15:0] actual  = vec_mode ? speed_rpm_i : out_freq_i;
    logic [15:0] job_val;
    always_comb begin
        case (job_r)
            2'h0:    job_val = actual;
            2'h1:    job_val = speed_ref_o;
            2'h2:    job_val = min_r;
            default: job_val = max_r;
        endcase
    end
    wire [31:0] num = job_val * scale_r;

    assign div_start = st_r == S_START;

    scale_div u_div (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .start_i  (div_start),
        .num_i    (num),
        .den_i    (den),
        .done_o   (div_done),
        .quo_o    (div_quo)
    );

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r     <= S_IDLE;
            job_r    <= 2'h0;
            dspeed_r <= 16'h0000;
            dref_r   <= 16'h0000;
            minlim_r <= 16'h0000;
            maxlim_r <= 16'h0000;
        end else begin
            case (st_r)
                S_IDLE:  st_r <= S_START;
                S_START: st_r <= S_WAIT;
                S_WAIT: begin
                    if (div_done) begin
                        case (job_r)
                            2'h0:    dspeed_r <= div_quo;
                            2'h1:    dref_r   <= div_quo;
                            2'h2:    minlim_r <= div_quo;
                            default: maxlim_r <= div_quo;
                        endcase
                        job_r <= job_r + 2'h1;
                        st_r  <= S_IDLE;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_ack_one_cycle: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    a_ack_after_req: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_norev_forward: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (policy == POL_NOREV) |=> !dir_rev_o)
        else $error("reverse seen under policy 1");
    a_panel_forced: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (policy == POL_NOREV) |-> !sw_rev)
        else $error("panel direction not forced forward");
    a_latch_holds: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (running_i && run_prev_r) |=> $stable(dir_latch_r))
        else $error("latch moved while running");
    a_latch_polarity: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (policy == POL_LATCH) |=> dir_rev_o ==
            ($past(dir_latch_r) ^ $past(ref_neg_i)))
        else $error("policy 2 direction wrong");
    a_scale_range: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        scale_r >= SCALE_MIN && scale_r <= SCALE_MAX)
        else $error("scale out of range");
    a_meter_clear: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        mreset_r |=> days_r == 16'h0000 && subday_r == 48'h0 && !mreset_r)
        else $error("meter reset did not clear");
    a_days_sat: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        days_r <= DAYS_MAX)
        else $error("days beyond limit");
    a_preset_pick: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (in_pre && preset_code != 3'h0) |=>
            speed_ref_o == $past(preset_r[preset_code]))
        else $error("wrong preset selected");

endmodule // drive_ref
`default_nettype wire

// ---- drive_ref_pkg.sv ----
// Contract
// - policy 0: follow requested direction freely
// - policy 1: no reverse, panel/serial forced forward
// - policy 1: negative reference still cannot reverse
// - policy 2: latch direction when running starts
// - policy 2: ignore direction requests while running
// - policy 2: reference polarity may still reverse
// - display scale held within 10 to 9999
// - vector display: speed times scale over top
// - volts-hertz display: freq times scale over base
// - manual reference clamped to scaled min/max
// - scale affects displays only, never the command
// - read-only powered days counter, 0 to 9999
// - meter reset on clears days and log clock
// - meter reset returns itself to off
// - eight presets, each within min and max speed when written; a later min or max write does not reclamp them
// - presets used only for sources 2 to 7
// - three switches form code, first is msb
// - code zero: preset one or analog by source
package drive_ref_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam int          ADR_W        = 8;
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_SCALE    = 8'h04;
    localparam logic [7:0]  OFS_TOP      = 8'h08;
    localparam logic [7:0]  OFS_BASE     = 8'h0c;
    localparam logic [7:0]  OFS_MIN      = 8'h10;
    localparam logic [7:0]  OFS_MAX      = 8'h14;
    localparam logic [7:0]  OFS_MANUAL   = 8'h18;
    localparam logic [7:0]  OFS_MRESET   = 8'h1c;
    localparam logic [7:0]  OFS_DAYS     = 8'h20;
    localparam logic [7:0]  OFS_LOGCLK   = 8'h24;
    localparam logic [7:0]  OFS_STATUS   = 8'h28;
    localparam logic [7:0]  OFS_DSPEED   = 8'h2c;
    localparam logic [7:0]  OFS_DREF     = 8'h30;
    localparam logic [7:0]  OFS_MINLIM   = 8'h34;
    localparam logic [7:0]  OFS_MAXLIM   = 8'h38;
    localparam logic [7:0]  OFS_MANLIM   = 8'h3c;
    localparam logic [7:0]  OFS_PRESET0  = 8'h40;
    localparam logic [7:0]  OFS_PRESET7  = 8'h5c;

    // ****************************************
    // control field positions
    // ****************************************
    localparam int          CTRL_POL_LSB = 0;
    localparam int          CTRL_VEC_BIT = 2;
    localparam int          CTRL_SRC_LSB = 3;
    localparam int          CTRL_REV_BIT = 6;
    localparam int          CTRL_TRM_BIT = 7;
    localparam logic [7:0]  CTRL_RST     = 8'h00;

    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [15:0] SCALE_RST    = 16'h0708;
    localparam logic [15:0] TOP_RST      = 16'h0708;
    localparam logic [15:0] BASE_RST     = 16'h003c;
    localparam logic [15:0] MIN_RST      = 16'h0000;
    localparam logic [15:0] MAX_RST      = 16'h003c;
    localparam logic [15:0] PRESET_RST   = 16'h0005;
    localparam logic [15:0] SCALE_MIN    = 16'h000a;
    localparam logic [15:0] SCALE_MAX    = 16'h270f;
    localparam logic [15:0] DAYS_MAX     = 16'h270f;

    // ****************************************
    // encodings
    // ****************************************
    localparam logic [1:0]  POL_FREE     = 2'h0;
    localparam logic [1:0]  POL_NOREV    = 2'h1;
    localparam logic [1:0]  POL_LATCH    = 2'h2;
    localparam logic [2:0]  SRC_PRE_LO   = 3'h2;
    localparam logic [2:0]  SRC_PRE_HI   = 3'h7;
    localparam logic [2:0]  SRC_ANA_LO   = 3'h5;

    // ****************************************
    // timing
    // ****************************************
    localparam longint      DAY_HOURS    = 24;
    localparam longint      CLK_HZ       = 250_000_000;
    localparam logic [47:0] DAY_CYCLES   = 48'(DAY_HOURS * 3600 * CLK_HZ);
    localparam logic [5:0]  DIV_STEPS    = 6'h20;

endpackage

// ---- scale_div.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// sequential restoring divider, saturating
// ****************************************
module scale_div
    import drive_ref_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // request
    input  wire logic        start_i,
    input  wire logic [31:0] num_i,
    input  wire logic [15:0] den_i,
    // answer
    output logic             done_o,
    output logic [15:0]      quo_o
);
    logic [31:0] q_r;
    logic [16:0] rem_r;
    logic [15:0] den_r;
    logic [5:0]  cnt_r;
    logic        busy_r;
    wire  [16:0] rem_sh  = {rem_r[15:0], q_r[31]};
    wire         fits    = rem_sh >= {1'b0, den_r};
    wire  [16:0] rem_nxt = fits ? rem_sh - {1'b0, den_r} : rem_sh;
    // a zero divisor or an oversize result reads as full scale
    wire         sat     = (den_r == 16'h0000) || (q_r[31:16] != 16'h0000);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_r    <= 32'h0;
            rem_r  <= 17'h0;
            den_r  <= 16'h0;
            cnt_r  <= 6'h0;
            busy_r <= 1'b0;
            done_o <= 1'b0;
            quo_o  <= 16'h0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_r) begin
                q_r    <= num_i;
                rem_r  <= 17'h0;
                den_r  <= den_i;
                cnt_r  <= 6'h0;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (cnt_r == DIV_STEPS) begin
                    busy_r <= 1'b0;
                    done_o <= 1'b1;
                    quo_o  <= sat ? 16'hffff : q_r[15:0];
                end else begin
                    rem_r <= rem_nxt;
                    q_r   <= {q_r[30:0], fits};
                    cnt_r <= cnt_r + 6'h1;
                end
            end
        end
    end
endmodule // scale_div
`default_nettype wire

// ---- strip_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// terminal strip switches and direction pin
// ****************************************
module strip_model (
    // clock
    input  wire logic       clk_i,
    // bench commands
    input  wire logic [2:0] code_i,
    input  wire logic       rev_i,
    // terminal strip pins
    output logic [2:0]      preset_sw_o,
    output logic            term_rev_o
);
    // contacts move one edge after the command, as a settled switch
    always @(posedge clk_i) begin
        preset_sw_o <= code_i;
        term_rev_o  <= rev_i;
    end
endmodule // strip_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import drive_ref_pkg::*;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [2:0]  code = 3'h0;
    logic        rev = 1'b0;
    logic [2:0]  sw;
    logic        trev;
    logic        run = 1'b0;
    logic        neg = 1'b0;
    logic [15:0] rpm = 16'h0;
    logic [15:0] freq = 16'h0;
    logic        dir;
    logic [15:0] sref;
    logic [15:0] q;
    int          fails = 0;
    int          n_tests = 0;
    always #2 clk_i = ~clk_i;
    strip_model sm (.clk_i(clk_i), .code_i(code), .rev_i(rev),
        .preset_sw_o(sw), .term_rev_o(trev));
    // a short day keeps the meter moving within the run
    drive_ref #(.DAY_CYCLES_P(48'd20)) dut (.clk_i(clk_i),
        .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .preset_sw_i(sw), .term_rev_i(trev), .running_i(run),
        .ref_neg_i(neg), .analog_ref_i(16'h0abc),
        .speed_rpm_i(rpm), .out_freq_i(freq), .dir_rev_o(dir),
        .speed_ref_o(sref));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // values read right at the edge are the pre-edge ones: race free
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
        int k;
        @(posedge clk_i);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {16'h0, d};
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        if (k == 20) begin
            fails++;
            print_verdict();
        end
        q = rdat[15:0];
        cyc <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0);
        cmp(q, e);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        chk(OFS_CTRL, 16'(CTRL_RST));
        chk(OFS_SCALE, SCALE_RST);
        chk(OFS_PRESET7, PRESET_RST);
        chk(8'h60, 16'h0000);
        wb(1'b1, OFS_SCALE, 16'h0005);
        chk(OFS_SCALE, SCALE_MIN);
        wb(1'b1, OFS_SCALE, 16'hffff);
        chk(OFS_SCALE, SCALE_MAX);
    endtask
    task automatic t_dir();
        wb(1'b1, OFS_CTRL, 16'h0080);
        rev <= 1'b1;
        tick(6);
        cmp(16'(dir), 16'h0001);
        neg <= 1'b1;
        tick(3);
        cmp(16'(dir), 16'h0000);
        wb(1'b1, OFS_CTRL, 16'h0081);
        tick(3);
        cmp(16'(dir), 16'h0000);
        neg <= 1'b0;
        wb(1'b1, OFS_CTRL, 16'h0041);
        chk(OFS_CTRL, 16'h0001);
        cmp(16'(dir), 16'h0000);
        wb(1'b1, OFS_CTRL, 16'h0082);
        rev <= 1'b0;
        tick(6);
        run <= 1'b1;
        tick(3);
        rev <= 1'b1;
        tick(6);
        cmp(16'(dir), 16'h0000);
        neg <= 1'b1;
        tick(3);
        cmp(16'(dir), 16'h0001);
        neg <= 1'b0;
        run <= 1'b0;
        tick(6);
        cmp(16'(dir), 16'h0001);
        run <= 1'b1;
        tick(2);
        rev <= 1'b0;
        tick(6);
        cmp(16'(dir), 16'h0001);
    endtask
    task automatic t_preset();
        int i;
        for (i = 0; i < 8; i++) begin
            wb(1'b1, OFS_PRESET0 + 8'(4 * i), 16'(16 + i));
        end
        wb(1'b1, OFS_CTRL, 16'h0010);
        for (i = 0; i < 8; i++) begin
            code <= 3'(i);
            tick(6);
            cmp(sref, 16'(16 + i));
        end
        wb(1'b1, OFS_PRESET7, 16'h0050);
        chk(OFS_PRESET7, MAX_RST);
        code <= 3'h0;
        wb(1'b1, OFS_CTRL, 16'h0028);
        tick(6);
        cmp(sref, 16'h0abc);
        wb(1'b1, OFS_CTRL, 16'h0000);
        code <= 3'h3;
        tick(6);
        cmp(sref, 16'h0abc);
    endtask
    task automatic t_display();
        wb(1'b1, OFS_CTRL, 16'h0004);
        wb(1'b1, OFS_SCALE, 16'h0064);
        rpm <= 16'd900;
        tick(200);
        chk(OFS_DSPEED, 16'h0032);
        wb(1'b1, OFS_CTRL, 16'h0000);
        wb(1'b1, OFS_SCALE, 16'h0320);
        wb(1'b1, OFS_MANUAL, 16'h1000);
        freq <= 16'd30;
        tick(200);
        chk(OFS_DSPEED, 16'h0190);
        chk(OFS_MAXLIM, 16'h0320);
        chk(OFS_MINLIM, 16'h0000);
        chk(OFS_MANLIM, 16'h0320);
        cmp(sref, 16'h0abc);
    endtask
    // a day tick may land just after the clear, so one day is allowed
    task automatic t_meter();
        wb(1'b1, OFS_MRESET, 16'h0001);
        wb(1'b0, OFS_DAYS, 16'h0000);
        cmp(16'(q <= 16'h0001), 16'h0001);
        chk(OFS_LOGCLK, 16'h0000);
        chk(OFS_MRESET, 16'h0000);
        wb(1'b1, OFS_DAYS, 16'h2000);
        tick(100);
        wb(1'b0, OFS_DAYS, 16'h0000);
        cmp(16'(q > 16'h0001 && q < 16'h0100), 16'h0001);
    endtask
    initial begin
        tick(5);
        resetn_i <= 1'b1;
        t_regs();
        t_dir();
        t_preset();
        t_display();
        t_meter();
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
